// ===== pkg/smst_pkg.sv
// constants shared by the supply manager status and telemetry block
package smst_pkg;
   // command codes that select a readback register
   localparam logic [7:0]  CMD_IN_STATUS   = 8'h7C;
   localparam logic [7:0]  CMD_TEMP_STATUS = 8'h7D;
   localparam logic [7:0]  CMD_CML_STATUS  = 8'h7E;
   localparam logic [7:0]  CMD_VEND_STATUS = 8'h80;
   localparam logic [7:0]  CMD_VIN_READ    = 8'h88;
   localparam logic [7:0]  CMD_VOUT_READ   = 8'h8B;
   localparam logic [7:0]  CMD_TEMP_READ   = 8'h8D;
   localparam logic [7:0]  CMD_PROTO_REV   = 8'h98;
   // bit positions in the comm/memory/logic status byte
   localparam int          CML_CMD         = 7;
   localparam int          CML_DATA        = 6;
   localparam int          CML_PEC         = 5;
   localparam int          CML_MEM         = 4;
   localparam int          CML_BUS         = 1;
   // bits 3, 2 and 0 are never set
   localparam logic [7:0]  CML_MASK        = 8'hF2;
   // link event slots, one toggle each
   localparam int          EV_CMD          = 0;
   localparam int          EV_DATA         = 1;
   localparam int          EV_PEC          = 2;
   localparam int          EV_BUS          = 3;
   localparam int          EV_CLR          = 4;
   localparam int          NUM_EV          = 5;
   // L11 exponent of -6: 15.6 uV per LSB equals 2^-6 mV
   localparam logic [4:0]  EXP_MV          = 5'h1A;
   localparam logic signed [15:0] MANT_MAX = 16'sh03FF;
   localparam logic signed [15:0] MANT_MIN = -16'sh0400;
   // reset values
   localparam logic [15:0] ANS_RST         = 16'h0000;
   localparam logic [2:0]  ZERO3           = 3'h0;
   localparam logic [3:0]  ZERO4           = 4'h0;
   localparam logic [7:0]  ZERO8           = 8'h00;
endpackage

// ===== verif/smst_host_model.sv
// host-side model: issues link reads and fault events on the link clock
module smst_host_model (
   input  wire logic        link_clk,
   output logic             lk_rd_req,
   output logic [7:0]       lk_cmd,
   output logic [2:0]       lk_page,
   output logic [4:0]       lk_ev,
   input  wire logic [15:0] lk_rd_data,
   input  wire logic        lk_rd_valid
);
   timeunit 1ns;
   timeprecision 1ps;
   // quiet at time zero, nothing requested before reset is released
   initial begin
      lk_rd_req = 1'b0;
      lk_cmd    = 8'h00;
      lk_page   = 3'h0;
      lk_ev     = 5'h00;
   end
   // one read; gap idles first to act as a slow host, the wait is bounded
   task automatic read(input logic [7:0] c, input logic [2:0] p, input int gap,
                       output logic [15:0] d);
      int n;
      n = 0;
      d = 16'hxxxx;
      repeat (gap + 1) @(posedge link_clk);
      lk_rd_req <= 1'b1;
      lk_cmd    <= c;
      lk_page   <= p;
      @(posedge link_clk);
      lk_rd_req <= 1'b0;
      // released: show a changed pattern so stale values are not mistaken
      lk_cmd    <= ~c;
      lk_page   <= ~p;
      while (lk_rd_valid !== 1'b1 && n < 12) begin
         @(posedge link_clk);
         n++;
      end
      if (lk_rd_valid === 1'b1) d = lk_rd_data;
   endtask
   // one-cycle event pulses, then idle long enough for a readback to see them
   task automatic ev(input logic [4:0] m);
      @(posedge link_clk);
      lk_ev <= m;
      @(posedge link_clk);
      lk_ev <= 5'h00;
      repeat (6) @(posedge link_clk);
   endtask
endmodule

// ===== verif/supply_manager_status_telemetry_tb_top.sv
// testbench for the status and telemetry readback block
module supply_manager_status_telemetry_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] REV = 8'h3C; // arbitrary, not a real revision code
   logic clk, link_clk, arst_n, lk_rd_req, lk_rd_valid, lk_busy, alert_line_n;
   logic [7:0] lk_cmd, ch_on_cmd, ch_on_attempt, ch_fault1_shutdown, ch_fault0_shutdown;
   logic [7:0] ch_discharge_fault, ch_servo_reached, ch_dac_connected, ch_dac_saturated;
   logic [7:0] ch_adc_hires, adc_vout_stb;
   logic [2:0] lk_page;
   logic [4:0] lk_ev;
   logic [15:0] lk_rd_data, adc_vin_l11, adc_vout_raw, adc_temp_l11;
   logic vin_ov_fault, vin_ov_warn, vin_uv_warn, vin_uv_fault, vin_off, eeprom_fault;
   logic temp_ot_fault, temp_ot_warn, temp_ut_warn, temp_ut_fault, vinen_faulted_off;
   logic watchdog_fault, shared_fault_line_0_n, shared_fault_line_1_n, adc_vin_stb;
   logic adc_temp_stb;
   int fails = 0;
   int total_checks = 0;
   int cyc = 0;
   smst_top #(.PROTO_REV(REV)) dut_u (.clk, .arst_n, .link_clk, .lk_rd_req, .lk_cmd,
      .lk_page, .lk_cmd_fault(lk_ev[smst_pkg::EV_CMD]), .lk_data_fault(lk_ev[smst_pkg::EV_DATA]),
      .lk_pec_fault(lk_ev[smst_pkg::EV_PEC]), .lk_bus_fault(lk_ev[smst_pkg::EV_BUS]),
      .lk_clear_faults(lk_ev[smst_pkg::EV_CLR]), .lk_rd_data, .lk_rd_valid, .lk_busy,
      .vin_ov_fault, .vin_ov_warn, .vin_uv_warn, .vin_uv_fault, .vin_off, .temp_ot_fault,
      .temp_ot_warn, .temp_ut_warn, .temp_ut_fault, .eeprom_fault, .ch_on_cmd, .ch_on_attempt,
      .ch_fault1_shutdown, .ch_fault0_shutdown, .ch_discharge_fault, .ch_servo_reached,
      .ch_dac_connected, .ch_dac_saturated, .ch_adc_hires, .vinen_faulted_off, .watchdog_fault,
      .shared_fault_line_0_n, .shared_fault_line_1_n, .adc_vin_stb, .adc_vin_l11, .adc_vout_stb,
      .adc_vout_raw, .adc_temp_stb, .adc_temp_l11, .alert_line_n);
   smst_host_model host_u (.link_clk, .lk_rd_req, .lk_cmd, .lk_page, .lk_ev, .lk_rd_data,
      .lk_rd_valid);
   // register clock, and a link clock offset so the two never line up
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   initial begin
      link_clk = 1'b0;
      #7;
      forever #24 link_clk = ~link_clk;
   end
   // hang guard, well above the length of all scenarios
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fails++;
         give_verdict();
      end
   end
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      total_checks++;
      if (g !== e) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic rdchk(input string nm, input logic [7:0] c, input logic [2:0] p,
                        input int gap, input logic [15:0] e);
      logic [15:0] d;
      host_u.read(c, p, gap, d);
      chk(nm, e, d);
   endtask
   task automatic clear();
      host_u.ev(5'h01 << smst_pkg::EV_CLR);
   endtask
   // alert sampled a little after the edge so its update has landed
   task automatic chk_alert(input logic e);
      @(posedge clk);
      #1;
      chk("alert", {15'h0000, e}, {15'h0000, alert_line_n});
   endtask
   task automatic s_input();
      @(posedge clk);
      {vin_ov_fault, vin_uv_fault, vin_off} <= 3'h7;
      @(posedge clk);
      {vin_ov_fault, vin_uv_fault} <= 2'h0;
      rdchk("input", smst_pkg::CMD_IN_STATUS, 3'h0, 0, 16'h0098);
      @(posedge clk);
      vin_off <= 1'b0;
      {vin_ov_warn, vin_uv_warn} <= 2'h3;
      @(posedge clk);
      {vin_ov_warn, vin_uv_warn} <= 2'h0;
      rdchk("input held", smst_pkg::CMD_IN_STATUS, 3'h0, 2, 16'h00F0);
      clear();
      rdchk("input clr", smst_pkg::CMD_IN_STATUS, 3'h0, 0, 16'h0000);
   endtask
   task automatic s_temp();
      @(posedge clk);
      {temp_ot_fault, temp_ot_warn, temp_ut_warn, temp_ut_fault} <= 4'hF;
      @(posedge clk);
      {temp_ot_fault, temp_ot_warn, temp_ut_warn, temp_ut_fault} <= 4'h0;
      rdchk("temp", smst_pkg::CMD_TEMP_STATUS, 3'h0, 0, 16'h00F0);
      clear();
      rdchk("temp clr", smst_pkg::CMD_TEMP_STATUS, 3'h0, 0, 16'h0000);
   endtask
   task automatic s_cml();
      host_u.ev(5'h0F);
      @(posedge clk);
      eeprom_fault <= 1'b1;
      @(posedge clk);
      eeprom_fault <= 1'b0;
      rdchk("cml", smst_pkg::CMD_CML_STATUS, 3'h0, 0, 16'h00F2);
      clear();
      rdchk("unknown cmd", 8'h55, 3'h0, 0, 16'h0000);
      rdchk("cml cmd", smst_pkg::CMD_CML_STATUS, 3'h0, 0, 16'h0080);
      clear();
      rdchk("cml clr", smst_pkg::CMD_CML_STATUS, 3'h0, 0, 16'h0000);
   endtask
   task automatic s_vendor();
      chk_alert(1'b1);
      @(posedge clk);
      {watchdog_fault, vinen_faulted_off, shared_fault_line_1_n} <= 3'h6;
      {ch_discharge_fault[2], ch_dac_saturated[2], ch_fault0_shutdown[4]} <= 3'h7;
      {ch_servo_reached[2], ch_dac_connected[2], ch_on_attempt[5]} <= 3'h7;
      @(posedge clk);
      {watchdog_fault, ch_discharge_fault, ch_dac_saturated, ch_fault0_shutdown} <= '0;
      repeat (2) chk_alert(1'b0);
      repeat (4) @(posedge clk);
      ch_on_attempt <= 8'h00;
      shared_fault_line_1_n <= 1'b1;
      rdchk("vendor p2", smst_pkg::CMD_VEND_STATUS, 3'h2, 0, 16'h009F);
      rdchk("vendor p5", smst_pkg::CMD_VEND_STATUS, 3'h5, 0, 16'h0043);
      rdchk("vendor p4", smst_pkg::CMD_VEND_STATUS, 3'h4, 0, 16'h0023);
      rdchk("vendor p3", smst_pkg::CMD_VEND_STATUS, 3'h3, 0, 16'h0003);
      @(posedge clk);
      {ch_on_cmd[2], ch_servo_reached[2], ch_dac_connected[2], vinen_faulted_off} <= 4'h8;
      @(posedge clk);
      ch_on_cmd <= 8'h00;
      rdchk("vendor on", smst_pkg::CMD_VEND_STATUS, 3'h2, 0, 16'h0001);
      clear();
      rdchk("vendor clr", smst_pkg::CMD_VEND_STATUS, 3'h5, 0, 16'h0000);
      chk_alert(1'b1);
   endtask
   task automatic s_adc();
      @(posedge clk);
      {adc_vin_stb, adc_temp_stb, adc_vout_stb, ch_adc_hires} <= {2'h3, 8'h0C, 8'h0C};
      {adc_vin_l11, adc_temp_l11, adc_vout_raw} <= {16'hD2A0, 16'hE1C0, 16'h0064};
      @(posedge clk);
      {adc_vin_stb, adc_temp_stb, adc_vout_stb} <= '0;
      rdchk("vin", smst_pkg::CMD_VIN_READ, 3'h0, 0, 16'hD2A0);
      rdchk("temp read", smst_pkg::CMD_TEMP_READ, 3'h0, 0, 16'hE1C0);
      rdchk("vout odd", smst_pkg::CMD_VOUT_READ, 3'h3, 0, 16'hD064);
      rdchk("vout even", smst_pkg::CMD_VOUT_READ, 3'h2, 0, 16'h0064);
      @(posedge clk);
      {adc_vout_stb, adc_vout_raw} <= {8'h08, 16'h07D0};
      @(posedge clk);
      adc_vout_stb <= 8'h00;
      rdchk("vout clamp", smst_pkg::CMD_VOUT_READ, 3'h3, 0, 16'hD3FF);
      rdchk("revision", smst_pkg::CMD_PROTO_REV, 3'h0, 1, {8'h00, REV});
   endtask
   // every clock-domain input starts quiet; fault pins idle high
   initial begin
      arst_n = 1'b0;
      {vin_ov_fault, vin_ov_warn, vin_uv_warn, vin_uv_fault, vin_off, eeprom_fault} = '0;
      {temp_ot_fault, temp_ot_warn, temp_ut_warn, temp_ut_fault, vinen_faulted_off} = '0;
      {ch_on_cmd, ch_on_attempt, ch_fault1_shutdown, ch_fault0_shutdown} = '0;
      {ch_discharge_fault, ch_servo_reached, ch_dac_connected, ch_dac_saturated} = '0;
      {ch_adc_hires, adc_vout_stb, watchdog_fault, adc_vin_stb, adc_temp_stb} = '0;
      {adc_vin_l11, adc_vout_raw, adc_temp_l11} = '0;
      {shared_fault_line_0_n, shared_fault_line_1_n} = 2'h3;
      repeat (2) @(posedge clk);
      arst_n <= 1'b1;
      repeat (3) @(posedge link_clk);
      s_input();
      s_temp();
      s_cml();
      s_vendor();
      s_adc();
      give_verdict();
   end
endmodule

// ===== verilog/smst_top.sv
// status and telemetry readback registers of an octal supply manager
// Overview of operation
// (RQ1) input status bits 7..4: input ov fault, ov warn, uv warn, uv fault
// (RQ2) input status bit 3 shows unit off for insufficient input voltage
// (RQ3) input status bits 2..0 and temperature status bits 3..0 read zero
// (RQ4) temperature status bits 7..4: ot fault, ot warn, ut warn, ut fault
// (RQ5) comm status bit 7 on illegal command, bit 6 on illegal data
// (RQ6) extra byte before stop, unless matching check byte, sets comm bit 5
// (RQ7) memory fault sets comm bit 4; clear faults resets it
// (RQ8) comm bit 1 flags any other malformed bus transaction
// (RQ9) comm status bits 3, 2 and 0 always read zero
// (RQ10) sticky vendor bits hold until clear faults or channel commanded on
// (RQ11) discharge, both fault-line and watchdog bits pull alert line low
// (RQ12) vendor bits 1..0 are global; bits 7..2 follow the selected page
// (RQ13) vendor bit 7 latches discharge fault while channel enters on state
// (RQ14) bits 6/5 set on turn-on with fault line low, or shutdown by it
// (RQ15) live bit 4 shows servo target reached, bit 3 trim output driven
// (RQ16) sticky bit 2 sets when servo ended at dac code limit
// (RQ17) global live bit 1 shows supply enable dropped by output fault
// (RQ18) global sticky bit 0 latches watchdog fault; alerting only
// (RQ19) input voltage readback returns latest L11 volts word
// (RQ20) output readback is L16 volts; odd hires channels give L11 millivolts
// (RQ21) temperature readback returns latest L11 junction temperature word
// (RQ22) protocol revision reads a fixed 8-bit value
// (RQ23) hires bit matters on odd channels only; even channels stay low res
// (RQ24) input, temperature and comm flags hold until clear faults; the code passes input bit 3 (unit off) through live from vin_off
module smst_top #(
   parameter int         NCH       = 8,
   // arbitrary value, not a real revision code
   parameter logic [7:0] PROTO_REV = 8'h22,
   localparam int        PW        = $clog2(NCH)
) (
   input  wire logic                  clk,
   input  wire logic                  arst_n,
   input  wire logic                  link_clk,
   input  wire logic                  lk_rd_req,
   input  wire logic [7:0]            lk_cmd,
   input  wire logic [PW-1:0]         lk_page,
   input  wire logic                  lk_cmd_fault,
   input  wire logic                  lk_data_fault,
   input  wire logic                  lk_pec_fault,
   input  wire logic                  lk_bus_fault,
   input  wire logic                  lk_clear_faults,
   output logic      [15:0]           lk_rd_data,
   output logic                       lk_rd_valid,
   output logic                       lk_busy,
   input  wire logic                  vin_ov_fault,
   input  wire logic                  vin_ov_warn,
   input  wire logic                  vin_uv_warn,
   input  wire logic                  vin_uv_fault,
   input  wire logic                  vin_off,
   input  wire logic                  temp_ot_fault,
   input  wire logic                  temp_ot_warn,
   input  wire logic                  temp_ut_warn,
   input  wire logic                  temp_ut_fault,
   input  wire logic                  eeprom_fault,
   input  wire logic [NCH-1:0]        ch_on_cmd,
   input  wire logic [NCH-1:0]        ch_on_attempt,
   input  wire logic [NCH-1:0]        ch_fault1_shutdown,
   input  wire logic [NCH-1:0]        ch_fault0_shutdown,
   input  wire logic [NCH-1:0]        ch_discharge_fault,
   input  wire logic [NCH-1:0]        ch_servo_reached,
   input  wire logic [NCH-1:0]        ch_dac_connected,
   input  wire logic [NCH-1:0]        ch_dac_saturated,
   input  wire logic [NCH-1:0]        ch_adc_hires,
   input  wire logic                  vinen_faulted_off,
   input  wire logic                  watchdog_fault,
   input  wire logic                  shared_fault_line_0_n,
   input  wire logic                  shared_fault_line_1_n,
   input  wire logic                  adc_vin_stb,
   input  wire logic [15:0]           adc_vin_l11,
   input  wire logic [NCH-1:0]        adc_vout_stb,
   input  wire logic [15:0]           adc_vout_raw,
   input  wire logic                  adc_temp_stb,
   input  wire logic [15:0]           adc_temp_l11,
   output logic                       alert_line_n
);
   timeunit 1ns;
   timeprecision 1ps;

   // state of the register side, clocked by clk
   typedef struct packed {
      logic [1:0]                req_sy;
      logic                      req_seen;
      logic [4:0]                ev_s1;
      logic [4:0]                ev_s2;
      logic [4:0]                ev_seen;
      logic [1:0]                pin_s1;
      logic [1:0]                pin_s2;
      logic                      ans_tgl;
      logic [15:0]               ans_data;
      logic [3:0]                in_lat;
      logic                      in_off;
      logic [3:0]                tmp_lat;
      logic [7:0]                cml_lat;
      logic [NCH-1:0]            dis;
      logic [NCH-1:0]            f1;
      logic [NCH-1:0]            f0;
      logic [NCH-1:0]            sat;
      logic                      wdog;
      logic                      alert_n;
      logic [15:0]               vin;
      logic [NCH-1:0][15:0]      vout;
      logic [15:0]               temp;
   } smst_main_t;

   // state of the link side, clocked by link_clk
   typedef struct packed {
      logic                      req_tgl;
      logic [7:0]                cmd;
      logic [PW-1:0]             page;
      logic                      busy;
      logic [4:0]                ev_tgl;
      logic                      ans_s1;
      logic                      ans_s2;
      logic                      ans_seen;
      logic [15:0]               rd_data;
      logic                      rd_valid;
   } smst_link_t;

   smst_main_t st_r;
   smst_main_t st_nxt;
   smst_link_t lk_r;
   smst_link_t lk_nxt;

   logic                         req_new;
   logic [4:0]                   ev_pulse;
   logic                         clr;
   logic [15:0]                  answer;
   logic [7:0]                   vend_byte;
   logic                         odd_hires;

   // clamp a signed count into an 11-bit mantissa
   function automatic logic [10:0] sat11(input logic signed [15:0] v);
      logic [10:0] m;
      m = v[10:0];
      if (v > smst_pkg::MANT_MAX) begin
         m = smst_pkg::MANT_MAX[10:0];
      end else if (v < smst_pkg::MANT_MIN) begin
         m = smst_pkg::MANT_MIN[10:0];
      end
      return m;
   endfunction

   // crossing edges seen on the register side
   assign req_new  = st_r.req_sy[1] ^ st_r.req_seen;
   assign ev_pulse = st_r.ev_s2 ^ st_r.ev_seen;
   assign clr      = ev_pulse[smst_pkg::EV_CLR];

   // vendor byte for the page latched by the link
   assign vend_byte = {st_r.dis[lk_r.page],          // see RQ13
                       st_r.f1[lk_r.page],           // see RQ14
                       st_r.f0[lk_r.page],           // see RQ14
                       ch_servo_reached[lk_r.page],  // see RQ15
                       ch_dac_connected[lk_r.page],  // see RQ15
                       st_r.sat[lk_r.page],          // see RQ16
                       vinen_faulted_off,            // see RQ17
                       st_r.wdog};                   // see RQ12

   // only odd channels honour the high resolution setting
   assign odd_hires = lk_r.page[0] && ch_adc_hires[lk_r.page];  // see RQ23

   // answer mux; cmd and page stay put while the link is busy
   always_comb begin
      answer = smst_pkg::ANS_RST;
      unique case (lk_r.cmd)
         smst_pkg::CMD_IN_STATUS:
            answer = {smst_pkg::ZERO8, st_r.in_lat, st_r.in_off,
                      smst_pkg::ZERO3};  // see RQ1, see RQ2, see RQ3
         smst_pkg::CMD_TEMP_STATUS:
            answer = {smst_pkg::ZERO8, st_r.tmp_lat,
                      smst_pkg::ZERO4};  // see RQ4, see RQ3
         smst_pkg::CMD_CML_STATUS:
            answer = {smst_pkg::ZERO8,
                      st_r.cml_lat & smst_pkg::CML_MASK};  // see RQ9
         smst_pkg::CMD_VEND_STATUS:
            answer = {smst_pkg::ZERO8, vend_byte};  // see RQ12
         smst_pkg::CMD_VIN_READ:
            answer = st_r.vin;  // see RQ19
         smst_pkg::CMD_VOUT_READ:
            if (odd_hires) begin
               answer = {smst_pkg::EXP_MV,
                         sat11(st_r.vout[lk_r.page])};  // see RQ20
            end else begin
               answer = st_r.vout[lk_r.page];  // see RQ20
            end
         smst_pkg::CMD_TEMP_READ:
            answer = st_r.temp;  // see RQ21
         smst_pkg::CMD_PROTO_REV:
            answer = {smst_pkg::ZERO8, PROTO_REV};  // see RQ22
         default:
            answer = smst_pkg::ANS_RST;
      endcase
   end

   // register side next state
   always_comb begin
      st_nxt = st_r;
      // two-flop synchronisers: stage one feeds stage two only
      st_nxt.req_sy  = {st_r.req_sy[0], lk_r.req_tgl};
      st_nxt.req_seen = st_r.req_sy[1];
      st_nxt.ev_s1   = lk_r.ev_tgl;
      st_nxt.ev_s2   = st_r.ev_s1;
      st_nxt.ev_seen = st_r.ev_s2;
      st_nxt.pin_s1  = {shared_fault_line_1_n, shared_fault_line_0_n};
      st_nxt.pin_s2  = st_r.pin_s1;

      // answer a read once the request toggle is seen
      if (req_new) begin
         st_nxt.ans_data = answer;
         st_nxt.ans_tgl  = ~st_r.ans_tgl;
      end

      // latched input flags; set wins over clear
      st_nxt.in_lat = (st_r.in_lat & {4{~clr}})
                    | {vin_ov_fault, vin_ov_warn,
                       vin_uv_warn, vin_uv_fault};  // see RQ1, see RQ24
      st_nxt.in_off = vin_off;  // see RQ2
      st_nxt.tmp_lat = (st_r.tmp_lat & {4{~clr}})
                     | {temp_ot_fault, temp_ot_warn,
                        temp_ut_warn, temp_ut_fault};  // see RQ4, see RQ24

      // comm, memory and logic flags
      st_nxt.cml_lat = st_r.cml_lat & {8{~clr}};  // see RQ24
      if (ev_pulse[smst_pkg::EV_CMD] || (req_new && answer_unknown(lk_r.cmd))) begin
         st_nxt.cml_lat[smst_pkg::CML_CMD] = 1'b1;  // see RQ5
      end
      if (ev_pulse[smst_pkg::EV_DATA]) begin
         st_nxt.cml_lat[smst_pkg::CML_DATA] = 1'b1;  // see RQ5
      end
      if (ev_pulse[smst_pkg::EV_PEC]) begin
         st_nxt.cml_lat[smst_pkg::CML_PEC] = 1'b1;  // see RQ6
      end
      if (eeprom_fault) begin
         st_nxt.cml_lat[smst_pkg::CML_MEM] = 1'b1;  // see RQ7
      end
      if (ev_pulse[smst_pkg::EV_BUS]) begin
         st_nxt.cml_lat[smst_pkg::CML_BUS] = 1'b1;  // see RQ8
      end

      // per-channel sticky bits; clear on clear faults or user turn-on
      for (int i = 0; i < NCH; i++) begin
         st_nxt.dis[i] = (st_r.dis[i] & ~clr & ~ch_on_cmd[i])
                       | ch_discharge_fault[i];  // see RQ10, see RQ13
         st_nxt.f1[i] = (st_r.f1[i] & ~clr & ~ch_on_cmd[i])
                      | (ch_on_attempt[i] & ~st_r.pin_s2[1])
                      | ch_fault1_shutdown[i];  // see RQ14
         st_nxt.f0[i] = (st_r.f0[i] & ~clr & ~ch_on_cmd[i])
                      | (ch_on_attempt[i] & ~st_r.pin_s2[0])
                      | ch_fault0_shutdown[i];  // see RQ14
         st_nxt.sat[i] = (st_r.sat[i] & ~clr & ~ch_on_cmd[i])
                       | ch_dac_saturated[i];  // see RQ16
         if (adc_vout_stb[i]) begin
            st_nxt.vout[i] = adc_vout_raw;  // see RQ20
         end
      end
      // watchdog is global and never tied to a channel turn-on
      st_nxt.wdog = (st_r.wdog & ~clr) | watchdog_fault;  // see RQ18

      // alerting bits only; servo and saturation bits stay quiet
      st_nxt.alert_n = ~((|st_r.dis) | (|st_r.f1) | (|st_r.f0)
                         | st_r.wdog);  // see RQ11

      // latest adc readings
      if (adc_vin_stb) begin
         st_nxt.vin = adc_vin_l11;  // see RQ19
      end
      if (adc_temp_stb) begin
         st_nxt.temp = adc_temp_l11;  // see RQ21
      end
   end

   // a command outside the readback set is reported as a command fault
   function automatic logic answer_unknown(input logic [7:0] c);
      return !(c inside {smst_pkg::CMD_IN_STATUS, smst_pkg::CMD_TEMP_STATUS,
                         smst_pkg::CMD_CML_STATUS, smst_pkg::CMD_VEND_STATUS,
                         smst_pkg::CMD_VIN_READ, smst_pkg::CMD_VOUT_READ,
                         smst_pkg::CMD_TEMP_READ, smst_pkg::CMD_PROTO_REV});
   endfunction

   // register side state
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         st_r         <= '0;
         st_r.alert_n <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   // link side next state; ans_data is stable once its toggle is seen
   always_comb begin
      lk_nxt          = lk_r;
      lk_nxt.rd_valid = 1'b0;
      lk_nxt.ans_s1   = st_r.ans_tgl;
      lk_nxt.ans_s2   = lk_r.ans_s1;
      lk_nxt.ev_tgl   = lk_r.ev_tgl ^ {lk_clear_faults, lk_bus_fault,
                                       lk_pec_fault, lk_data_fault,
                                       lk_cmd_fault};  // see RQ5, see RQ6
      // a request while busy is dropped; the link must wait
      if (lk_rd_req && !lk_r.busy) begin
         lk_nxt.cmd     = lk_cmd;
         lk_nxt.page    = lk_page;
         lk_nxt.req_tgl = ~lk_r.req_tgl;
         lk_nxt.busy    = 1'b1;
      end
      if (lk_r.ans_s2 != lk_r.ans_seen) begin
         lk_nxt.ans_seen = lk_r.ans_s2;
         lk_nxt.rd_data  = st_r.ans_data;
         lk_nxt.rd_valid = 1'b1;
         lk_nxt.busy     = 1'b0;
      end
   end

   // link side state
   always_ff @(posedge link_clk or negedge arst_n) begin
      if (!arst_n) begin
         lk_r <= '0;
      end else begin
         lk_r <= lk_nxt;
      end
   end

   // outputs straight from flops
   assign lk_rd_data   = lk_r.rd_data;
   assign lk_rd_valid  = lk_r.rd_valid;
   assign lk_busy      = lk_r.busy;
   assign alert_line_n = st_r.alert_n;

   // checks on the register side
   AST_IN_HOLD: assert property (@(posedge clk) disable iff (!arst_n)
      st_r.in_lat[3] && !clr |=> st_r.in_lat[3])  // see RQ24
      else $error("input ov fault flag dropped without clear");

   AST_ALERT: assert property (@(posedge clk) disable iff (!arst_n)
      (|st_r.dis) || st_r.wdog |=> !alert_line_n)  // see RQ11
      else $error("alert line not low with alerting bit set");

   AST_QUIET: assert property (@(posedge clk) disable iff (!arst_n)
      !((|st_r.dis) || (|st_r.f1) || (|st_r.f0) || st_r.wdog)
      |=> alert_line_n)  // see RQ11
      else $error("alert line low with no alerting bit");

   AST_WDOG: assert property (@(posedge clk) disable iff (!arst_n)
      watchdog_fault ##1 !clr |=> st_r.wdog)  // see RQ18
      else $error("watchdog bit did not hold");

   AST_TMP_CLR: assert property (@(posedge clk) disable iff (!arst_n)
      clr && !temp_ot_fault && !temp_ot_warn && !temp_ut_warn
      && !temp_ut_fault |=> st_r.tmp_lat == smst_pkg::ZERO4)  // see RQ4
      else $error("temperature flags survived clear");

   AST_MEM: assert property (@(posedge clk) disable iff (!arst_n)
      eeprom_fault |=> st_r.cml_lat[smst_pkg::CML_MEM])  // see RQ7
      else $error("memory fault bit not set");

   AST_ON_CLR: assert property (@(posedge clk) disable iff (!arst_n)
      ch_on_cmd[2] && !ch_dac_saturated[2] |=> !st_r.sat[2])  // see RQ10
      else $error("sticky bit kept after turn-on command");

   AST_REV: assert property (@(posedge clk) disable iff (!arst_n)
      req_new && lk_r.cmd == smst_pkg::CMD_PROTO_REV
      |=> st_r.ans_data == {smst_pkg::ZERO8, PROTO_REV})  // see RQ22
      else $error("revision readback wrong");

   AST_VOUT_HI: assert property (@(posedge clk) disable iff (!arst_n)
      req_new && lk_r.cmd == smst_pkg::CMD_VOUT_READ && odd_hires
      |=> st_r.ans_data[15:11] == smst_pkg::EXP_MV)  // see RQ20
      else $error("odd hires readback not in millivolt form");

   AST_PIN_F1: assert property (@(posedge clk) disable iff (!arst_n)
      ch_on_attempt[5] && !st_r.pin_s2[1] |=> st_r.f1[5])  // see RQ14
      else $error("fault line bit not set on turn-on attempt");

   // checks on the link side
   AST_ANS_TIME: assert property (@(posedge link_clk) disable iff (!arst_n)
      lk_rd_req && !lk_busy |=> ##[1:8] lk_rd_valid)  // see RQ12
      else $error("read answer late");

   AST_VALID_PULSE: assert property (@(posedge link_clk) disable iff (!arst_n)
      lk_rd_valid |=> !lk_rd_valid && !lk_busy)  // see RQ19
      else $error("read valid longer than one cycle");

   // main scenarios
   COV_READ: cover property (@(posedge link_clk) disable iff (!arst_n)
      lk_rd_req && !lk_busy ##[1:8] lk_rd_valid);
   COV_ALERT: cover property (@(posedge clk) disable iff (!arst_n)
      $fell(alert_line_n));
   COV_CLEAR: cover property (@(posedge clk) disable iff (!arst_n)
      clr && (|st_r.cml_lat));
   COV_HIRES: cover property (@(posedge clk) disable iff (!arst_n)
      req_new && odd_hires && lk_r.cmd == smst_pkg::CMD_VOUT_READ);

endmodule
